// ===== hdl/pol_prot_pkg.sv
// Constants, field layouts and carrier types for the protection manager.
// Assumes one 100 MHz regulator clock and 12-bit voltage codes of 2.5 mV.
package pol_prot_pkg;
  localparam logic [7:0] PT_OFF        = 8'h01;
  localparam logic [7:0] CL_OFF        = 8'h08;
  localparam logic [7:0] PT_RST        = 8'h08;
  localparam logic [7:0] CL_RST        = 8'h1B;
  localparam logic [7:0] PT_MASK       = 8'h3F;
  localparam int         PGU_BIT       = 5;
  localparam int         PGL_BIT       = 4;
  localparam int         OVL_LSB       = 2;
  localparam int         UVL_LSB       = 0;
  localparam int         SLOPE_LSB     = 5;
  localparam int         TCE_BIT       = 4;
  localparam logic [3:0] CODE_MAX      = 4'hB;
  localparam logic [7:0] PGU_HI_PCT    = 8'd110;
  localparam logic [7:0] PGU_LO_PCT    = 8'd105;
  localparam logic [7:0] PGL_HI_PCT    = 8'd95;
  localparam logic [7:0] PGL_LO_PCT    = 8'd90;
  localparam logic [7:0] OV0_PCT       = 8'd110;
  localparam logic [7:0] OV1_PCT       = 8'd120;
  localparam logic [7:0] OV2_PCT       = 8'd130;
  localparam logic [7:0] UV_BASE_PCT   = 8'd75;
  localparam logic [7:0] UV_STEP_PCT   = 8'd5;
  localparam logic [7:0] TW_SET_C      = 8'd120;
  localparam logic [7:0] TW_CLR_C      = 8'd117;
  localparam logic [7:0] OT_TRIP_C     = 8'd130;
  localparam logic [7:0] TC_BASE_C     = 8'd25;
  localparam int         LSB_UV        = 2500;
  localparam int         OV_MIN_MV     = 500;
  localparam int         OV_MARGIN_MV  = 250;
  localparam int         TRK_MV        = 250;
  localparam logic [11:0] OV_MIN_CODE  = 12'(OV_MIN_MV * 1000 / LSB_UV);
  localparam logic [11:0] OV_MARG_CODE = 12'(OV_MARGIN_MV * 1000 / LSB_UV);
  localparam logic [11:0] TRK_CODE     = 12'(TRK_MV * 1000 / LSB_UV);
  localparam logic [7:0] PG_DLY_MAX_MS = 8'd150;
  localparam logic [7:0] RETRY_MS      = 8'd130;
  localparam int         CLK_NS        = 10;
  localparam int         MS_NS         = 1000000;
  localparam int         MS_CYC        = MS_NS / CLK_NS;

  typedef enum logic [1:0] {OFF_NONE, OFF_REG, OFF_FAST, OFF_CLAMP} off_style_t;

  // Active-low protection flags, warning bit active high
  typedef struct packed {
    logic hot_warning_bit;
    logic pgood;
    logic overcurrent_flag;
    logic undervolt_flag;
    logic overtemp_flag;
    logic tracking_flag;
    logic overvolt_flag;
  } flags_t;

  localparam flags_t FLAGS_RST = 7'h1F;

  typedef struct packed {
    logic [7:0]  pt;
    logic [7:0]  cl;
    logic [7:0]  rdata;
    logic [2:0]  sync;
    logic        pg_pin;
    flags_t      flags;
    logic        pg_oe;
    logic        pg_lvl;
    logic [7:0]  pg_ms;
    logic        trk_done;
    logic        off;
    logic        cause_ot;
    logic [7:0]  retry_ms;
    logic [31:0] ms_cnt;
    off_style_t  style;
    logic        shutdown;
    logic        restart;
  } state_t;
endpackage

// ===== hdl/pol_protection_manager.sv
// Protection, warning and turn-off selection logic of the regulator.
// Assumes sensed values arrive synchronous to sys_clk; only the power-good
// pin comes from outside and is synchronised here.
//
// Function
// - Threshold register writable only while PWM stopped
// - Bit 5 picks upper limit 105/110 percent
// - Bit 4 picks lower limit 95/90 percent
// - Bits 3:2 pick overvoltage 110/120/130 percent
// - Bits 1:0 pick undervoltage 75..90 percent
// - Thresholds scale with present output setpoint
// - Current limit bits 7:5 select load slope
// - Bit 4 enables overcurrent temperature compensation
// - Current limit code 37..140 percent, clamped
// - Hot warning above 120, clears below 117
// - Outside window pull power-good low, flag zero
// - Power-good after steady state, release delayed
// - External low on pin is a warning
// - Pin low at command or ramp-down start
// - Overcurrent above prebias, fast turn-off
// - Undervoltage in steady state, regular turn-off
// - Overtemperature above 130, regular turn-off
// - Non-latching overtemperature restarts below 120
// - Tracking error over 250 mV, fast turn-off
// - Tracking ends at power-good, re-armed only while run_en low
// - Overvoltage above prebias clamps low side on
// - Overvoltage threshold at least 0.5 V, setpoint+0.25 V
// - Non-latching retries every 130 ms unless overtemperature was the sole cause, latching stays
`timescale 1ns/1ps
module pol_protection_manager import pol_prot_pkg::*; #(
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [7:0]  cfg_wdata,
  output      logic [7:0]  cfg_rdata,
  input  wire logic        run_en,
  input  wire logic        ramp_up,
  input  wire logic        steady,
  input  wire logic        ramp_down,
  input  wire logic        off_cmd,
  input  wire logic        above_prebias,
  input  wire logic [11:0] vout_code,
  input  wire logic [11:0] vset_code,
  input  wire logic [11:0] vramp_code,
  input  wire logic [7:0]  iout_pct,
  input  wire logic [7:0]  temp_c,
  input  wire logic        trk_dis,
  input  wire logic        latching,
  input  wire logic        pg_at_cmd,
  input  wire logic [7:0]  pg_dly_ms,
  input  wire logic        pgood_i,
  output      logic        pgood_o,
  output      logic        pgood_oe,
  output      flags_t      protection_status,
  output      off_style_t  off_style,
  output      logic        shutdown,
  output      logic        restart,
  output      logic [2:0]  load_slope_sel
);

  state_t st_r;
  state_t st_nxt;

  function automatic logic [11:0] pct_of(input logic [11:0] v, input logic [7:0] p);
    logic [19:0] t;
    t = (20'(v) * 20'(p)) / 20'd100;
    return t[11:0];
  endfunction

  function automatic logic [7:0] ilim_pct(input logic [3:0] c);
    logic [7:0] p;
    case ((c > CODE_MAX) ? CODE_MAX : c)
      4'h0: p = 8'd37;
      4'h1: p = 8'd47;
      4'h2: p = 8'd56;
      4'h3: p = 8'd65;
      4'h4: p = 8'd75;
      4'h5: p = 8'd84;
      4'h6: p = 8'd93;
      4'h7: p = 8'd103;
      4'h8: p = 8'd112;
      4'h9: p = 8'd121;
      4'hA: p = 8'd131;
      default: p = 8'd140;
    endcase
    return p;
  endfunction

  logic [11:0] pgh_th;
  logic [11:0] pgl_th;
  logic [11:0] ov_pct_th;
  logic [11:0] ov_th;
  logic [11:0] uv_th;
  logic [11:0] trk_diff;
  logic [7:0]  ilim;
  logic [7:0]  ov_pct;
  logic        ms_tick;
  logic        in_win;
  logic        pg_ok;
  logic        ov_hit;
  logic        oc_hit;
  logic        tr_hit;
  logic        uv_hit;
  logic        ot_hit;

  always_comb begin
    pgh_th = pct_of(vset_code, st_r.pt[PGU_BIT] ? PGU_LO_PCT : PGU_HI_PCT);
    pgl_th = pct_of(vset_code, st_r.pt[PGL_BIT] ? PGL_HI_PCT : PGL_LO_PCT);
    case (st_r.pt[OVL_LSB+:2])
      2'b00:   ov_pct = OV0_PCT;
      2'b01:   ov_pct = OV1_PCT;
      default: ov_pct = OV2_PCT;
    endcase
    ov_pct_th = pct_of(vset_code, ov_pct);
    ov_th = (ov_pct_th < OV_MIN_CODE) ? OV_MIN_CODE : ov_pct_th;
    if (ov_th < vset_code + OV_MARG_CODE) begin
      ov_th = vset_code + OV_MARG_CODE;
    end
    uv_th = pct_of(vset_code, 8'(UV_BASE_PCT + UV_STEP_PCT * st_r.pt[UVL_LSB+:2]));
    ilim = ilim_pct(st_r.cl[3:0]);
    if (st_r.cl[TCE_BIT] && temp_c > TC_BASE_C) begin
      ilim = ilim + 8'((temp_c - TC_BASE_C) >> 3);
    end
    trk_diff = (vout_code > vramp_code) ? vout_code - vramp_code : vramp_code - vout_code;
    ms_tick = (st_r.ms_cnt >= 32'(MS_CYCLES - 1));
    in_win = (vout_code >= pgl_th) && (vout_code <= pgh_th);
    pg_ok = steady && in_win && !st_r.off && !(pg_at_cmd ? off_cmd : ramp_down);
    ov_hit = run_en && !st_r.off && above_prebias && (vout_code > ov_th);
    oc_hit = run_en && !st_r.off && above_prebias && (iout_pct >= ilim);
    tr_hit = run_en && !st_r.off && ramp_up && !trk_dis && !st_r.trk_done
             && (trk_diff > TRK_CODE);
    uv_hit = run_en && !st_r.off && steady && (vout_code < uv_th) && !oc_hit;
    ot_hit = !st_r.off && (temp_c > OT_TRIP_C);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.shutdown = 1'b0;
    st_nxt.restart = 1'b0;
    st_nxt.sync = {st_r.sync[1:0], pgood_i};
    if (st_r.sync[1] == st_r.sync[2]) begin
      st_nxt.pg_pin = st_r.sync[2];
    end
    st_nxt.ms_cnt = ms_tick ? 32'h0 : st_r.ms_cnt + 32'h1;
    if (cfg_wr) begin
      if (cfg_addr == PT_OFF) begin
        if (!run_en) begin
          st_nxt.pt = cfg_wdata & PT_MASK;
        end
      end else if (cfg_addr == CL_OFF) begin
        st_nxt.cl = cfg_wdata;
      end
    end
    if (cfg_addr == PT_OFF) begin
      st_nxt.rdata = st_r.pt;
    end else if (cfg_addr == CL_OFF) begin
      st_nxt.rdata = st_r.cl;
    end else begin
      st_nxt.rdata = 8'h00;
    end
    if (temp_c > TW_SET_C) begin
      st_nxt.flags.hot_warning_bit = 1'b1;
    end else if (temp_c < TW_CLR_C) begin
      st_nxt.flags.hot_warning_bit = 1'b0;
    end
    if (!pg_ok) begin
      st_nxt.pg_oe = 1'b1;
      st_nxt.pg_ms = 8'h00;
    end else if (st_r.pg_ms >= pg_dly_ms || st_r.pg_ms >= PG_DLY_MAX_MS) begin
      st_nxt.pg_oe = 1'b0;
    end else if (ms_tick) begin
      st_nxt.pg_ms = st_r.pg_ms + 8'h01;
    end
    st_nxt.flags.pgood = st_r.pg_pin;
    if (!run_en) begin
      st_nxt.trk_done = 1'b0;
    end else if (st_r.pg_oe && !st_nxt.pg_oe) begin
      st_nxt.trk_done = 1'b1;
    end
    if (ov_hit || oc_hit || tr_hit || uv_hit || ot_hit) begin
      st_nxt.off = 1'b1;
      st_nxt.shutdown = 1'b1;
      st_nxt.retry_ms = 8'h00;
      st_nxt.cause_ot = ot_hit && !ov_hit && !oc_hit && !tr_hit && !uv_hit;
      if (ov_hit) begin
        st_nxt.style = OFF_CLAMP;
      end else if (oc_hit || tr_hit) begin
        st_nxt.style = OFF_FAST;
      end else begin
        st_nxt.style = OFF_REG;
      end
      if (ov_hit) st_nxt.flags.overvolt_flag = 1'b0;
      if (oc_hit) st_nxt.flags.overcurrent_flag = 1'b0;
      if (tr_hit) st_nxt.flags.tracking_flag = 1'b0;
      if (uv_hit) st_nxt.flags.undervolt_flag = 1'b0;
      if (ot_hit) st_nxt.flags.overtemp_flag = 1'b0;
    end else if (st_r.off && !latching) begin
      if (st_r.cause_ot) begin
        st_nxt.restart = (temp_c < TW_SET_C);
      end else if (ms_tick) begin
        st_nxt.retry_ms = st_r.retry_ms + 8'h01;
        st_nxt.restart = (st_r.retry_ms + 8'h01 >= RETRY_MS) && (temp_c <= OT_TRIP_C);
      end
      if (st_nxt.restart) begin
        st_nxt.off = 1'b0;
        st_nxt.style = OFF_NONE;
        st_nxt.flags = {st_nxt.flags.hot_warning_bit, st_nxt.flags.pgood, 5'h1F};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{pt: PT_RST, cl: CL_RST, rdata: 8'h00, sync: 3'h0, pg_pin: 1'b0,
                flags: FLAGS_RST, pg_oe: 1'b1, pg_lvl: 1'b0, pg_ms: 8'h00,
                trk_done: 1'b0, off: 1'b0, cause_ot: 1'b0, retry_ms: 8'h00,
                ms_cnt: 32'h0, style: OFF_NONE, shutdown: 1'b0, restart: 1'b0};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata = st_r.rdata;
  assign pgood_o = st_r.pg_lvl;
  assign pgood_oe = st_r.pg_oe;
  assign protection_status = st_r.flags;
  assign off_style = st_r.style;
  assign shutdown = st_r.shutdown;
  assign restart = st_r.restart;
  assign load_slope_sel = st_r.cl[SLOPE_LSB+:3];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_pin_low;
    (clk_en && !pgood_i)[*5];
  endsequence

  a_pt_write_lock: assert property (clk_en && cfg_wr && cfg_addr == PT_OFF && run_en
    |=> $stable(st_r.pt)) else $error("threshold register changed while running");
  a_ov_clamp_style: assert property (clk_en && ov_hit
    |=> off_style == OFF_CLAMP && !protection_status.overvolt_flag && shutdown)
    else $error("overvoltage did not clamp");
  a_oc_fast_off: assert property (clk_en && oc_hit && !ov_hit
    |=> off_style == OFF_FAST && !protection_status.overcurrent_flag)
    else $error("overcurrent did not fast turn-off");
  a_uv_regular_off: assert property (clk_en && uv_hit && !ov_hit && !tr_hit
    |=> off_style == OFF_REG && !protection_status.undervolt_flag)
    else $error("undervoltage did not regular turn-off");
  a_trk_fast_off: assert property (clk_en && tr_hit && !ov_hit
    |=> off_style == OFF_FAST && !protection_status.tracking_flag)
    else $error("tracking fault did not fast turn-off");
  a_hot_warn_hyst: assert property (clk_en && protection_status.hot_warning_bit
    && temp_c >= TW_CLR_C |=> protection_status.hot_warning_bit)
    else $error("hot warning dropped inside hysteresis");
  a_ov_floor: assert property (vset_code < 12'hF00
    |-> ov_th >= OV_MIN_CODE && ov_th >= vset_code + OV_MARG_CODE)
    else $error("overvoltage threshold below floor");
  a_pg_ext_low: assert property (s_pin_low |=> !protection_status.pgood)
    else $error("external low not seen as warning");
  a_pg_off_cmd: assert property (clk_en && pg_at_cmd && off_cmd |=> pgood_oe)
    else $error("power-good not pulled at turn-off command");
  a_ot_restart: assert property (clk_en && st_r.off && st_r.cause_ot && !latching
    && temp_c < TW_SET_C |=> restart) else $error("no restart after cooling");
  a_latched_off: assert property (st_r.off && latching |=> !restart)
    else $error("latched fault restarted");
endmodule

// ===== tb/cfg_host_model.sv
// Power manager model: register writes and reads, power-good pull-up.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] cfg_rdata,
  input  wire logic       pgood_oe,
  input  wire logic       ext_pull,
  output      logic       cfg_wr,
  output      logic [7:0] cfg_addr,
  output      logic [7:0] cfg_wdata,
  output      logic       pgood_i
);
  // Pin high by pull-up unless a party pulls it
  assign pgood_i = !(pgood_oe || ext_pull);
  initial begin
    cfg_wr    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_wdata = 8'h00;
  end
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr    <= 1'b0;
    cfg_wdata <= ~d;
  endtask
  // Read data one cycle after address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    cfg_addr <= a;
    @(posedge sys_clk);
    #1 d = cfg_rdata;
  endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the protection manager.
// Assumes a 1 ms tick of 10 cycles; the host model drives the register port.
`timescale 1ns/1ps
module tb_top import pol_prot_pkg::*; ;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en, run_en, ramp_up, steady, ramp_down, off_cmd, above_prebias;
  logic        trk_dis, latching, pg_at_cmd, ext_pull;
  logic [11:0] vout_code, vset_code, vramp_code;
  logic [7:0]  iout_pct, temp_c, pg_dly_ms, cfg_addr, cfg_wdata, cfg_rdata, rv;
  logic        cfg_wr, pgood_i, pgood_o, pgood_oe, shutdown, restart;
  logic [2:0]  load_slope_sel;
  flags_t      protection_status;
  off_style_t  off_style;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n;

  always #5 sys_clk = ~sys_clk;

  pol_protection_manager #(.MS_CYCLES(10)) pol_protection_manager_i (
    .sys_clk, .reset_n, .clk_en, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .run_en, .ramp_up, .steady, .ramp_down, .off_cmd, .above_prebias,
    .vout_code, .vset_code, .vramp_code, .iout_pct, .temp_c, .trk_dis,
    .latching, .pg_at_cmd, .pg_dly_ms, .pgood_i, .pgood_o, .pgood_oe,
    .protection_status, .off_style, .shutdown, .restart, .load_slope_sel);

  cfg_host_model cfg_host_model_i (
    .sys_clk, .cfg_rdata, .pgood_oe, .ext_pull, .cfg_wr, .cfg_addr, .cfg_wdata,
    .pgood_i);

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic dflt();
    clk_en <= 1'b1;
    {run_en, ramp_up, steady, ramp_down, off_cmd, above_prebias} <= '0;
    {trk_dis, latching, pg_at_cmd, ext_pull, iout_pct, pg_dly_ms} <= '0;
    {vout_code, vset_code, vramp_code} <= {3{12'd400}};
    temp_c <= 8'd25;
  endtask

  task automatic rst();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    dflt();
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    tick(1);
  endtask

  task automatic wait_rel();
    n = 0;
    while (pgood_oe !== 1'b0 && n < 80) begin
      tick(1);
      n++;
    end
  endtask

  task automatic t_regs();
    cfg_host_model_i.rd(8'h01, rv);
    chk("thr reset", rv, 12'h008);
    cfg_host_model_i.rd(8'h08, rv);
    chk("lim reset", rv, 12'h01B);
    chk("status reset", protection_status, 12'h01F);
    cfg_host_model_i.wr(8'h08, 8'hE5);
    cfg_host_model_i.rd(8'h08, rv);
    chk("lim write", rv, 12'h0E5);
    chk("slope", load_slope_sel, 12'h007);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    cfg_host_model_i.wr(8'h08, 8'h3B);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    cfg_host_model_i.rd(8'h08, rv);
    chk("lim frozen", rv, 12'h0E5);
    @(posedge sys_clk);
    run_en <= 1'b1;
    cfg_host_model_i.wr(8'h01, 8'h04);
    cfg_host_model_i.rd(8'h01, rv);
    chk("thr locked", rv, 12'h008);
    @(posedge sys_clk);
    run_en <= 1'b0;
    cfg_host_model_i.wr(8'h01, 8'hFF);
    cfg_host_model_i.rd(8'h01, rv);
    chk("thr write", rv, 12'h03F);
    cfg_host_model_i.rd(8'h20, rv);
    chk("unmapped", rv, 12'h000);
    $display("end regs");
  endtask

  task automatic t_ov(input logic lt);
    rst();
    @(posedge sys_clk);
    latching <= lt;
    run_en <= 1'b1;
    above_prebias <= 1'b1;
    vout_code <= 12'd520;
    tick(2);
    chk("ov edge", off_style, OFF_NONE);
    @(posedge sys_clk);
    vout_code <= 12'd521;
    iout_pct <= 8'd200;
    tick(1);
    chk("ov trip", shutdown, 1'b1);
    chk("ov style", off_style, OFF_CLAMP);
    chk("ov status", protection_status, 12'h00E);
    @(posedge sys_clk);
    vout_code <= 12'd400;
    iout_pct <= 8'd0;
    n = 0;
    while (restart !== 1'b1 && n < 1400) begin
      tick(1);
      n++;
    end
    chk("retry", (n > 1270 && n < 1310), !lt);
    $display("end ov");
  endtask

  task automatic t_oc();
    rst();
    cfg_host_model_i.wr(8'h08, 8'h0F);
    @(posedge sys_clk);
    run_en <= 1'b1;
    above_prebias <= 1'b1;
    temp_c <= 8'd60;
    iout_pct <= 8'd139;
    tick(2);
    chk("oc edge", off_style, OFF_NONE);
    @(posedge sys_clk);
    iout_pct <= 8'd140;
    tick(1);
    chk("oc style", off_style, OFF_FAST);
    chk("oc status", protection_status, 12'h00F);
    $display("end oc");
  endtask

  task automatic t_uv();
    rst();
    cfg_host_model_i.wr(8'h01, 8'h0B);
    @(posedge sys_clk);
    run_en <= 1'b1;
    steady <= 1'b1;
    vout_code <= 12'd360;
    tick(2);
    chk("uv edge", off_style, OFF_NONE);
    @(posedge sys_clk);
    vset_code <= 12'd404;
    tick(1);
    chk("uv style", off_style, OFF_REG);
    chk("uv status", protection_status, 12'h017);
    $display("end uv");
  endtask

  task automatic t_ot();
    rst();
    @(posedge sys_clk);
    temp_c <= 8'd121;
    tick(1);
    chk("warn set", protection_status.hot_warning_bit, 1'b1);
    @(posedge sys_clk);
    temp_c <= 8'd118;
    tick(2);
    chk("warn hold", protection_status.hot_warning_bit, 1'b1);
    chk("warn no off", off_style, OFF_NONE);
    @(posedge sys_clk);
    temp_c <= 8'd116;
    tick(1);
    chk("warn clear", protection_status.hot_warning_bit, 1'b0);
    @(posedge sys_clk);
    temp_c <= 8'd131;
    tick(1);
    chk("ot style", off_style, OFF_REG);
    chk("ot status", protection_status, 12'h05B);
    @(posedge sys_clk);
    temp_c <= 8'd125;
    tick(3);
    chk("ot held", off_style, OFF_REG);
    @(posedge sys_clk);
    temp_c <= 8'd119;
    tick(3);
    chk("ot restart", off_style, OFF_NONE);
    $display("end ot");
  endtask

  task automatic t_trk();
    rst();
    @(posedge sys_clk);
    run_en <= 1'b1;
    ramp_up <= 1'b1;
    trk_dis <= 1'b1;
    vramp_code <= 12'd200;
    vout_code <= 12'd350;
    tick(2);
    chk("trk off", off_style, OFF_NONE);
    @(posedge sys_clk);
    trk_dis <= 1'b0;
    vout_code <= 12'd300;
    tick(2);
    chk("trk edge", off_style, OFF_NONE);
    @(posedge sys_clk);
    vout_code <= 12'd301;
    tick(1);
    chk("trk style", off_style, OFF_FAST);
    chk("trk status", protection_status, 12'h01D);
    $display("end trk");
  endtask

  task automatic t_pg();
    rst();
    @(posedge sys_clk);
    run_en <= 1'b1;
    steady <= 1'b1;
    pg_dly_ms <= 8'd2;
    wait_rel();
    chk("pg delay", (n > 8 && n < 40), 1'b1);
    tick(12);
    chk("pg flag", protection_status.pgood, 1'b1);
    @(posedge sys_clk);
    ext_pull <= 1'b1;
    tick(12);
    chk("pg ext", protection_status.pgood, 1'b0);
    @(posedge sys_clk);
    ext_pull <= 1'b0;
    off_cmd <= 1'b1;
    tick(3);
    chk("pg ramp", pgood_oe, 1'b0);
    @(posedge sys_clk);
    pg_at_cmd <= 1'b1;
    tick(2);
    chk("pg cmd", pgood_oe, 1'b1);
    @(posedge sys_clk);
    off_cmd <= 1'b0;
    wait_rel();
    @(posedge sys_clk);
    vout_code <= 12'd430;
    tick(2);
    chk("pg upper", pgood_oe, 1'b0);
    chk("pg level", pgood_o, 1'b0);
    @(posedge sys_clk);
    vout_code <= 12'd441;
    tick(2);
    chk("pg window", pgood_oe, 1'b1);
    $display("end pg");
  endtask

  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    dflt();
    rst();
    t_regs();
    t_ov(1'b0);
    t_ov(1'b1);
    t_oc();
    t_uv();
    t_ot();
    t_trk();
    t_pg();
    tally_and_finish();
  end
endmodule
